//--- logic/srsc_top.sv
// Reset status and peripheral reset control register slice.
// Behaviour
// [RQ1] Read-only 32-bit part identification register holds the part code.
// [RQ2] Reset cause register resets to 0x1, power-on flag only.
// [RQ3] Lockup event sets bit 8 and resets the chip.
// [RQ4] Lockup with debug probe attached sets bit 8, no chip reset.
// [RQ5] Writing 1 to the core reset bit sets cause bit 7.
// [RQ6] Core system reset request sets cause bit 5.
// [RQ7] Brownout detector reset sets cause bit 4.
// [RQ8] Low-voltage reset sets cause bit 3.
// [RQ9] Watchdog or window watchdog reset sets cause bit 2.
// [RQ10] External reset pin sets cause bit 1.
// [RQ11] Power-on or whole-chip reset bit sets cause bit 0.
// [RQ12] Cause flags clear only by writing 1; set wins over clear.
// [RQ13] Control register A holds the listed reset bits, reset zero.
// [RQ14] A set reset bit holds its controller in reset until written 0.
// [RQ15] Core and chip bits return to 0 after two clock cycles.
// [RQ16] Chip bit acts as power-on reset including configuration reload.
// [RQ17] Control A writes need unlock keys 59h,16h,88h in sequence.
// [RQ18] Reserved bits read zero and ignore writes.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "srsc_params.svh"
module srsc_top
    import srsc_pkg::*;
#(
    parameter logic [31:0] PART_CODE = `SRSC_PART_CODE // Arbitrary value.
) (
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    input  wire srsc_bus_s    bus,
    output logic [31:0]       rdata,
    input  wire srsc_events_s events,
    output logic [31:0]       prst_a,
    output logic [31:0]       prst_b,
    output logic [31:0]       prst_c,
    output logic              chip_reset_req,
    output logic              config_reload_req,
    output logic              core_reset_req,
    output logic              irq
);

    // ==========================================================
    // Decode
    logic         wr_cause;
    logic         wr_a;
    logic         wr_b;
    logic         wr_c;
    logic         wr_unlock;
    logic         wr_mask;
    srsc_unlock_e unlock_q;
    assign wr_cause  = bus.wr && bus.addr == `SRSC_OFF_CAUSE;
    assign wr_a      = bus.wr && bus.addr == `SRSC_OFF_PRST_A;
    assign wr_b      = bus.wr && bus.addr == `SRSC_OFF_PRST_B;
    assign wr_c      = bus.wr && bus.addr == `SRSC_OFF_PRST_C;
    assign wr_unlock = bus.wr && bus.addr == `SRSC_OFF_UNLOCK;
    assign wr_mask   = bus.wr && bus.addr == `SRSC_OFF_IRQ_MASK;

    // ==========================================================
    // Unlock sequence
    // Once open the lock stays open until zero is written to the unlock register;
    // any other bus write mid-sequence aborts the key sequence.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            unlock_q <= SRSC_LOCKED;
        end else if (bus.wr && unlock_q != SRSC_OPEN) begin
            unique case (unlock_q)
                SRSC_LOCKED: unlock_q <= (wr_unlock &&
                    bus.wdata == `SRSC_KEY_1) ? SRSC_KEY1 : SRSC_LOCKED; // RQ17
                SRSC_KEY1:   unlock_q <= (wr_unlock &&
                    bus.wdata == `SRSC_KEY_2) ? SRSC_KEY2 : SRSC_LOCKED; // RQ17
                SRSC_KEY2:   unlock_q <= (wr_unlock &&
                    bus.wdata == `SRSC_KEY_3) ? SRSC_OPEN : SRSC_LOCKED; // RQ17
                SRSC_OPEN:   unlock_q <= SRSC_OPEN;
            endcase
        end else if (wr_unlock && bus.wdata == 32'h0000_0000) begin
            unlock_q <= SRSC_LOCKED;
        end
    end

    // ==========================================================
    // Peripheral reset control
    logic [31:0] prst_a_q;
    logic [31:0] prst_b_q;
    logic [31:0] prst_c_q;
    logic [1:0]  core_cnt_q;
    logic [1:0]  chip_cnt_q;
    logic        a_ok;
    assign a_ok = wr_a && unlock_q == SRSC_OPEN;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prst_a_q <= `SRSC_PRST_A_RESET; // RQ13
        end else begin
            if (a_ok) begin
                prst_a_q <= bus.wdata & `SRSC_PRST_A_MASK; // RQ13 RQ18
            end
            if (core_cnt_q == 2'(`SRSC_ONE_SHOT_CYC - 1)) begin
                prst_a_q[`SRSC_BIT_CORE] <= 1'b0; // RQ15
            end
            if (chip_cnt_q == 2'(`SRSC_ONE_SHOT_CYC - 1)) begin
                prst_a_q[`SRSC_BIT_CHIP] <= 1'b0; // RQ15
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            core_cnt_q <= 2'h0;
            chip_cnt_q <= 2'h0;
        end else begin
            core_cnt_q <= prst_a_q[`SRSC_BIT_CORE] ? core_cnt_q + 2'h1 : 2'h0;
            chip_cnt_q <= prst_a_q[`SRSC_BIT_CHIP] ? chip_cnt_q + 2'h1 : 2'h0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prst_b_q <= 32'h0000_0000;
            prst_c_q <= 32'h0000_0000;
        end else begin
            if (wr_b) begin
                prst_b_q <= bus.wdata & `SRSC_PRST_B_MASK; // RQ18
            end
            if (wr_c) begin
                prst_c_q <= bus.wdata & `SRSC_PRST_C_MASK; // RQ18
            end
        end
    end
    // Lines are driven straight from the register, so the controllers
    // stay in reset for as long as the bit reads one.
    assign prst_a = prst_a_q; // RQ14
    assign prst_b = prst_b_q; // RQ14
    assign prst_c = prst_c_q; // RQ14
    assign core_reset_req = prst_a_q[`SRSC_BIT_CORE];
    assign chip_reset_req = prst_a_q[`SRSC_BIT_CHIP] |
                            (events.lockup & ~events.debug_attached); // RQ3 RQ4
    assign config_reload_req = prst_a_q[`SRSC_BIT_CHIP]; // RQ16

    // ==========================================================
    // Reset cause flags
    // This block must sit on a reset that survives the resets it records.
    logic [31:0] cause_q;
    logic [31:0] cause_set;
    logic [31:0] mask_q;
    always_comb begin
        cause_set = 32'h0000_0000;
        cause_set[`SRSC_BIT_LOCKUP]   = events.lockup; // RQ3 RQ4
        cause_set[`SRSC_BIT_CORE_SW]  = a_ok &&
                                        bus.wdata[`SRSC_BIT_CORE]; // RQ5
        cause_set[`SRSC_BIT_SYS_REQ]  = events.sys_request; // RQ6
        cause_set[`SRSC_BIT_BROWNOUT] = events.brownout; // RQ7
        cause_set[`SRSC_BIT_LOW_VOLT] = events.low_voltage; // RQ8
        cause_set[`SRSC_BIT_WATCHDOG] = events.watchdog; // RQ9
        cause_set[`SRSC_BIT_PIN]      = events.pin; // RQ10
        cause_set[`SRSC_BIT_POWER_ON] = events.power_on |
            (a_ok && bus.wdata[`SRSC_BIT_CHIP]); // RQ11
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cause_q <= `SRSC_CAUSE_RESET; // RQ2
        end else begin
            cause_q <= ((cause_q & ~(wr_cause ? bus.wdata : 32'h0)) |
                        cause_set) & `SRSC_CAUSE_MASK; // RQ12 RQ18
        end
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mask_q <= 32'h0000_0000;
        end else if (wr_mask) begin
            mask_q <= bus.wdata & `SRSC_CAUSE_MASK;
        end
    end
    assign irq = |(cause_q & mask_q);

    // ==========================================================
    // Read data
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata <= 32'h0000_0000;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `SRSC_OFF_PART_ID:  rdata <= PART_CODE; // RQ1
                `SRSC_OFF_CAUSE:    rdata <= cause_q;
                `SRSC_OFF_PRST_A:   rdata <= prst_a_q;
                `SRSC_OFF_PRST_B:   rdata <= prst_b_q;
                `SRSC_OFF_PRST_C:   rdata <= prst_c_q;
                `SRSC_OFF_UNLOCK:   rdata <= {31'h0, unlock_q == SRSC_OPEN};
                `SRSC_OFF_IRQ_MASK: rdata <= mask_q;
                default:            rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // Checks
    locked_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_a && unlock_q != SRSC_OPEN |=> $stable(prst_a_q[31:2]))
        else $error("locked write changed control A"); // RQ17
    one_shot_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(prst_a_q[`SRSC_BIT_CORE]) |-> ##2 !prst_a_q[`SRSC_BIT_CORE])
        else $error("core bit not cleared after two cycles"); // RQ15
    chip_shot_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(prst_a_q[`SRSC_BIT_CHIP]) |-> ##2 !prst_a_q[`SRSC_BIT_CHIP])
        else $error("chip bit not cleared after two cycles"); // RQ15
    lockup_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        events.lockup |=> cause_q[`SRSC_BIT_LOCKUP])
        else $error("lockup flag not set"); // RQ3
    debug_lockup_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        events.lockup && events.debug_attached && !prst_a_q[0]
        |-> !chip_reset_req)
        else $error("chip reset under debug lockup"); // RQ4
    sticky_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cause_q[`SRSC_BIT_PIN] && !(wr_cause && bus.wdata[`SRSC_BIT_PIN])
        |=> cause_q[`SRSC_BIT_PIN])
        else $error("flag lost without clear"); // RQ12
    wdog_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        events.watchdog |=> cause_q[`SRSC_BIT_WATCHDOG])
        else $error("watchdog flag not set"); // RQ9
    reserved_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cause_q & ~`SRSC_CAUSE_MASK) == 32'h0)
        else $error("reserved cause bit set"); // RQ18

    // ==========================================================
    // Reset values
    // These run without a disable so that the reset branch is checked too.
    cause_reset_a: assert property (@(posedge core_clk)
        !reset_n |=> cause_q == `SRSC_CAUSE_RESET)
        else $error("cause reset value wrong"); // RQ2
    ctrl_reset_a: assert property (@(posedge core_clk)
        !reset_n |=> prst_a_q == `SRSC_PRST_A_RESET)
        else $error("control A reset value wrong"); // RQ13
    other_reset_a: assert property (@(posedge core_clk)
        !reset_n |=> prst_b_q == 32'h0000_0000 && prst_c_q == 32'h0000_0000)
        else $error("control B or C reset value wrong"); // RQ13
    lock_reset_a: assert property (@(posedge core_clk)
        !reset_n |=> unlock_q == SRSC_LOCKED)
        else $error("unlock state not locked after reset"); // RQ17
    irq_reset_a: assert property (@(posedge core_clk)
        !reset_n |=> !irq)
        else $error("interrupt raised after reset"); // RQ2

    // ==========================================================
    // Event flags
    sys_req_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        events.sys_request |=> cause_q[`SRSC_BIT_SYS_REQ])
        else $error("system request flag not set"); // RQ6
    brownout_flag_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        events.brownout |=> cause_q[`SRSC_BIT_BROWNOUT])
        else $error("brownout flag not set"); // RQ7
    low_volt_flag_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        events.low_voltage |=> cause_q[`SRSC_BIT_LOW_VOLT])
        else $error("low-voltage flag not set"); // RQ8
    pin_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        events.pin |=> cause_q[`SRSC_BIT_PIN])
        else $error("pin flag not set"); // RQ10
    power_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        events.power_on |=> cause_q[`SRSC_BIT_POWER_ON])
        else $error("power-on flag not set"); // RQ11
    core_sw_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        a_ok && bus.wdata[`SRSC_BIT_CORE] |=> cause_q[`SRSC_BIT_CORE_SW])
        else $error("core software reset flag not set"); // RQ5
    chip_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        a_ok && bus.wdata[`SRSC_BIT_CHIP] |=> cause_q[`SRSC_BIT_POWER_ON])
        else $error("chip reset did not set power-on flag"); // RQ11
    lockup_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        events.lockup && !events.debug_attached |-> chip_reset_req)
        else $error("lockup did not request chip reset"); // RQ3
    debug_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        events.lockup && events.debug_attached
        |=> cause_q[`SRSC_BIT_LOCKUP])
        else $error("lockup flag lost under debug"); // RQ4

    // ==========================================================
    // Write-one-to-clear
    // An event in the same cycle as the clear must win, or a reset that
    // lands during the handler would go unrecorded.
    pin_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_cause && bus.wdata[`SRSC_BIT_PIN] && !events.pin
        |=> !cause_q[`SRSC_BIT_PIN])
        else $error("pin flag not cleared"); // RQ12
    wdog_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_cause && bus.wdata[`SRSC_BIT_WATCHDOG] && !events.watchdog
        |=> !cause_q[`SRSC_BIT_WATCHDOG])
        else $error("watchdog flag not cleared"); // RQ12
    set_wins_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_cause && bus.wdata[`SRSC_BIT_WATCHDOG] && events.watchdog
        |=> cause_q[`SRSC_BIT_WATCHDOG])
        else $error("clear beat a new watchdog event"); // RQ12
    power_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_cause && bus.wdata[`SRSC_BIT_POWER_ON] && !events.power_on &&
        !(a_ok && bus.wdata[`SRSC_BIT_CHIP])
        |=> !cause_q[`SRSC_BIT_POWER_ON])
        else $error("power-on flag not cleared"); // RQ12
    zero_keeps_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_cause && !bus.wdata[`SRSC_BIT_POWER_ON] &&
        cause_q[`SRSC_BIT_POWER_ON]
        |=> cause_q[`SRSC_BIT_POWER_ON])
        else $error("writing zero cleared a flag"); // RQ12

    // ==========================================================
    // Peripheral reset control
    open_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        a_ok |=> (prst_a_q & 32'hFFFF_FFFC) ==
        ($past(bus.wdata) & `SRSC_PRST_A_MASK & 32'hFFFF_FFFC))
        else $error("unlocked write to control A lost"); // RQ13
    hold_lines_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !a_ok |=> prst_a_q[31:2] == $past(prst_a_q[31:2]))
        else $error("reset line released without a write"); // RQ14
    core_high_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(prst_a_q[`SRSC_BIT_CORE]) |=> prst_a_q[`SRSC_BIT_CORE])
        else $error("core bit shorter than two cycles"); // RQ15
    chip_high_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(prst_a_q[`SRSC_BIT_CHIP]) |=> prst_a_q[`SRSC_BIT_CHIP])
        else $error("chip bit shorter than two cycles"); // RQ15
    config_reload_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        prst_a_q[`SRSC_BIT_CHIP] |-> config_reload_req && chip_reset_req)
        else $error("chip bit did not reload configuration"); // RQ16
    core_request_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        prst_a_q[`SRSC_BIT_CORE] |-> core_reset_req)
        else $error("core bit did not reset the core"); // RQ5
    reserved_a_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (prst_a_q & ~`SRSC_PRST_A_MASK) == 32'h0)
        else $error("reserved control A bit set"); // RQ18
    reserved_b_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (prst_b_q & ~`SRSC_PRST_B_MASK) == 32'h0)
        else $error("reserved control B bit set"); // RQ18
    reserved_c_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (prst_c_q & ~`SRSC_PRST_C_MASK) == 32'h0)
        else $error("reserved control C bit set"); // RQ18
    write_b_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_b |=> prst_b_q == ($past(bus.wdata) & `SRSC_PRST_B_MASK))
        else $error("control B write lost"); // RQ14

    // ==========================================================
    // Unlock sequence
    key_first_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        unlock_q == SRSC_LOCKED && wr_unlock && bus.wdata == `SRSC_KEY_1
        |=> unlock_q == SRSC_KEY1)
        else $error("first key not taken"); // RQ17
    key_second_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        unlock_q == SRSC_KEY1 && wr_unlock && bus.wdata == `SRSC_KEY_2
        |=> unlock_q == SRSC_KEY2)
        else $error("second key not taken"); // RQ17
    key_third_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        unlock_q == SRSC_KEY2 && wr_unlock && bus.wdata == `SRSC_KEY_3
        |=> unlock_q == SRSC_OPEN)
        else $error("third key did not open"); // RQ17
    abort_first_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        unlock_q == SRSC_KEY1 && bus.wr &&
        !(wr_unlock && bus.wdata == `SRSC_KEY_2)
        |=> unlock_q == SRSC_LOCKED)
        else $error("bad second write did not abort"); // RQ17
    abort_second_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        unlock_q == SRSC_KEY2 && bus.wr &&
        !(wr_unlock && bus.wdata == `SRSC_KEY_3)
        |=> unlock_q == SRSC_LOCKED)
        else $error("bad third write did not abort"); // RQ17
    relock_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        unlock_q == SRSC_OPEN && wr_unlock && bus.wdata == 32'h0
        |=> unlock_q == SRSC_LOCKED)
        else $error("zero write did not relock"); // RQ17
    stay_open_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        unlock_q == SRSC_OPEN && !(wr_unlock && bus.wdata == 32'h0)
        |=> unlock_q == SRSC_OPEN)
        else $error("open lock closed on its own"); // RQ17

    // ==========================================================
    // Read data and interrupt
    read_part_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        bus.rd && bus.addr == `SRSC_OFF_PART_ID |=> rdata == PART_CODE)
        else $error("part code read wrong"); // RQ1
    read_cause_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        bus.rd && bus.addr == `SRSC_OFF_CAUSE |=> rdata == $past(cause_q))
        else $error("cause read wrong"); // RQ2
    read_ctrl_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        bus.rd && bus.addr == `SRSC_OFF_PRST_A |=> rdata == $past(prst_a_q))
        else $error("control A read wrong"); // RQ13
    read_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !bus.rd |=> rdata == 32'h0000_0000)
        else $error("read data without a read"); // RQ18
    read_hole_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        bus.rd && bus.addr > `SRSC_OFF_IRQ_MASK |=> rdata == 32'h0000_0000)
        else $error("unmapped read not zero"); // RQ18
    irq_level_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cause_q[`SRSC_BIT_WATCHDOG] && mask_q[`SRSC_BIT_WATCHDOG] |-> irq)
        else $error("unmasked flag without interrupt"); // RQ9

endmodule : srsc_top

//--- logic/srsc_params.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SRSC_PARAMS_SVH
`define SRSC_PARAMS_SVH
`define SRSC_OFF_PART_ID     8'h00
`define SRSC_OFF_CAUSE       8'h04
`define SRSC_OFF_PRST_A      8'h08
`define SRSC_OFF_PRST_B      8'h0C
`define SRSC_OFF_PRST_C      8'h10
`define SRSC_OFF_UNLOCK      8'h14
`define SRSC_OFF_IRQ_MASK    8'h18
`define SRSC_CAUSE_RESET     32'h0000_0001
`define SRSC_CAUSE_MASK      32'h0000_01BF
`define SRSC_PRST_A_RESET    32'h0000_0000
`define SRSC_PRST_A_MASK     32'h2000_10DF
`define SRSC_PRST_B_MASK     32'hBF3FF7BE
`define SRSC_PRST_C_MASK     32'h0CF30747
`define SRSC_BIT_POWER_ON    0
`define SRSC_BIT_PIN         1
`define SRSC_BIT_WATCHDOG    2
`define SRSC_BIT_LOW_VOLT    3
`define SRSC_BIT_BROWNOUT    4
`define SRSC_BIT_SYS_REQ     5
`define SRSC_BIT_CORE_SW     7
`define SRSC_BIT_LOCKUP      8
`define SRSC_BIT_CHIP        0
`define SRSC_BIT_CORE        1
`define SRSC_KEY_1           32'h0000_0059
`define SRSC_KEY_2           32'h0000_0016
`define SRSC_KEY_3           32'h0000_0088
`define SRSC_ONE_SHOT_CYC    2
`define SRSC_PART_CODE       32'h1234_0000
`endif

//--- logic/srsc_pkg.sv
// Types shared by the reset status and control block.
`include "srsc_params.svh"
package srsc_pkg;
    typedef enum logic [1:0] {
        SRSC_LOCKED = 2'b00,
        SRSC_KEY1   = 2'b01,
        SRSC_KEY2   = 2'b10,
        SRSC_OPEN   = 2'b11
    } srsc_unlock_e;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } srsc_bus_s;
    typedef struct packed {
        logic lockup;
        logic debug_attached;
        logic sys_request;
        logic brownout;
        logic low_voltage;
        logic watchdog;
        logic pin;
        logic power_on;
    } srsc_events_s;
endpackage : srsc_pkg

//--- bench/test_srsc_top.sv
// Self-checking bench for the reset status and control slice.
`timescale 1ns/1ps
`include "srsc_params.svh"
module test_srsc_top
    import srsc_pkg::*;
;
    // ==========================================================
    // Signals
    // Arbitrary value.
    localparam logic [31:0] TB_PART = 32'hA5A5_0000;
    logic         core_clk;
    logic         reset_n;
    srsc_bus_s    bus;
    srsc_events_s events;
    logic [31:0]  rdata;
    logic [31:0]  prst_a;
    logic [31:0]  prst_b;
    logic [31:0]  prst_c;
    logic         chip_reset_req;
    logic         config_reload_req;
    logic         core_reset_req;
    logic         irq;
    int           miscompares;
    int           samples_checked;
    int           eb[7] = '{7, 5, 4, 3, 2, 1, 0};
    int           cb[7] = '{8, 5, 4, 3, 2, 1, 0};

    srsc_top #(.PART_CODE(TB_PART)) dut (
        .core_clk          (core_clk),
        .reset_n           (reset_n),
        .bus               (bus),
        .rdata             (rdata),
        .events            (events),
        .prst_a            (prst_a),
        .prst_b            (prst_b),
        .prst_c            (prst_c),
        .chip_reset_req    (chip_reset_req),
        .config_reload_req (config_reload_req),
        .core_reset_req    (core_reset_req),
        .irq               (irq)
    );

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One strobe cycle, then idle, so no signal is driven twice at an edge.
    task automatic acc(input logic w, input logic r, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge core_clk);
        bus <= '0;
        #1;
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string what);
        acc(1'b0, 1'b1, a, 32'h0000_0000);
        chk(rdata, e, what);
    endtask : rd

    task automatic pulse(input int b, input logic dbg);
        logic [7:0] v;
        v = 8'h00;
        v[b] = 1'b1;
        v[6] = dbg;
        @(posedge core_clk);
        events <= v;
        #1;
        chk({31'h0, chip_reset_req}, {31'h0, b == 7 && !dbg},
            "chip req");
        @(posedge core_clk);
        events <= '0;
    endtask : pulse

    task automatic oneshot(input logic [31:0] d, input logic [4:0] e,
                           input logic [31:0] cause);
        wr(8'h08, d);
        for (int k = 0; k < 3; k++) begin
            chk({27'h0, core_reset_req, config_reload_req, chip_reset_req,
                 prst_a[1:0]}, (k < 2) ? {27'h0, e} : 32'h0, "one-shot");
            @(posedge core_clk);
            #1;
        end
        rd(8'h04, cause, "one-shot cause");
        wr(8'h04, cause);
    endtask : oneshot

    task automatic unlock();
        wr(8'h14, `SRSC_KEY_1);
        wr(8'h14, `SRSC_KEY_2);
        wr(8'h14, `SRSC_KEY_3);
    endtask : unlock

    task automatic final_report();
        $display("miscompares=%0d samples_checked=%0d", miscompares,
                 samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // ==========================================================
    // Clock, watchdog and test sequence
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // About 150 cycles are needed; twenty times that marks a hang.
    initial begin
        #(3000 * 25);
        miscompares++;
        final_report();
    end

    initial begin
        reset_n = 1'b0;
        bus = '0;
        events = '0;
        miscompares = 0;
        samples_checked = 0;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(8'h00, TB_PART, "part code");
        rd(8'h04, 32'h0000_0001, "cause reset");
        for (int i = 2; i < 5; i++) rd(8'(i * 4), 32'h0, "ctrl reset");
        rd(8'h40, 32'h0000_0000, "unmapped");
        wr(8'h04, 32'h0000_0000);
        rd(8'h04, 32'h0000_0001, "write 0 keeps");
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, 32'h0000_0000, "w1c");
        foreach (eb[i]) begin
            pulse(eb[i], 1'b0);
            rd(8'h04, 32'h1 << cb[i], "ev");
            wr(8'h04, 32'h1 << cb[i]);
        end
        pulse(7, 1'b1);
        rd(8'h04, 32'h0000_0100, "lockup debug");
        wr(8'h04, 32'h0000_0100);
        wr(8'h08, 32'hFFFF_FFFC);
        rd(8'h08, 32'h0000_0000, "locked write");
        wr(8'h14, `SRSC_KEY_1);
        wr(8'h14, `SRSC_KEY_2);
        wr(8'h18, 32'h0000_0000);
        wr(8'h14, `SRSC_KEY_3);
        wr(8'h08, 32'hFFFF_FFFC);
        rd(8'h08, 32'h0000_0000, "aborted unlock");
        unlock();
        wr(8'h08, 32'hFFFF_FFFC);
        rd(8'h08, 32'h2000_10DC, "ctrl a bits");
        chk(prst_a, 32'h2000_10DC, "reset lines held");
        wr(8'h08, 32'h0000_0000);
        chk(prst_a, 32'h0000_0000, "reset released");
        oneshot(32'h2, 5'b10010, 32'h80);
        oneshot(32'h1, 5'b01101, 32'h1);
        wr(8'h14, 32'h0000_0000);
        wr(8'h08, 32'h0000_0004);
        rd(8'h08, 32'h0000_0000, "relocked");
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C, `SRSC_PRST_B_MASK, "ctrl b");
        chk(prst_b, `SRSC_PRST_B_MASK, "lines b");
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, `SRSC_PRST_C_MASK, "ctrl c");
        chk(prst_c, `SRSC_PRST_C_MASK, "lines c");
        wr(8'h18, 32'h0000_0004);
        pulse(2, 1'b0);
        #2;
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(8'h18, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(8'h18, 32'h0000_0004);
        wr(8'h04, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        final_report();
    end
endmodule : test_srsc_top
